// [logic/tc2_timer.sv]
// Eight-bit up/down timer with two compare channels and waveform pin override
//
// What this block does
// RULE1 - Count value zero is the bottom of the sequence.
// RULE2 - Count value all ones is the maximum.
// RULE3 - Top is the maximum or compare value A, by waveform mode.
// RULE4 - Timer clock is the core clock unless async select picks the oscillator.
// RULE5 - Each timer clock clears, increments or decrements by direction and mode.
// RULE6 - Clock select zero stops counting; counter stays readable and writable.
// RULE7 - A processor counter write beats any clear or count.
// RULE8 - Three-bit waveform mode: two bits in control A, one in control B.
// RULE9 - Overflow flag sets per waveform mode and can raise an interrupt.
// RULE10 - Counter equal to a compare value sets that flag at the timer clock.
// RULE11 - Enabled compare flag interrupts; cleared by acknowledge or writing one.
// RULE12 - PWM modes double buffer compare values, loaded at top or bottom.
// RULE13 - Buffered: accesses reach the buffer; otherwise the active compare value.
// RULE14 - Force strobe in non-PWM modes acts like a match without flag or clear.
// RULE15 - A counter write blocks compare matches on the next timer clock.
// RULE16 - Output state survives waveform mode changes.
// RULE17 - Output mode bits act immediately, from the next match.
// RULE18 - Nonzero output mode puts the waveform on the pin; direction stays external.
// RULE19 - Output mode zero leaves the output state unchanged at a match.
// RULE20 - Software should set the output state before enabling pin drive.
// RULE21 - Software should not write bottom to the counter while counting down.
// RULE22 - Mode zero counts up, wraps to zero, overflow set as count becomes zero.
// RULE23 - Mode two clears the counter on a match with compare value A.
// RULE24 - Fast PWM is single slope; top is maximum in mode three, A in seven.
// RULE25 - Oscillator clocking is brought into the core clock before use.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module tc2_timer (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   arst_n,
   // Register port
   input  wire logic [tc2_pkg::AW-1:0] reg_addr,
   input  wire logic [tc2_pkg::DW-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [tc2_pkg::DW-1:0]      reg_rdata,
   // Interrupt requests and acknowledges (overflow, compare A, compare B)
   output logic [2:0]                  irq,
   input  wire logic [2:0]             int_ack,
   // Oscillator pin
   input  wire logic                   osc_in_pin,
   // General port values for the two waveform pins
   input  wire logic                   port_out_a,
   input  wire logic                   port_out_b,
   input  wire logic                   wave_pin_direction_a,
   input  wire logic                   wave_pin_direction_b,
   // Waveform pins
   output logic                        wave_out_a,
   output logic                        wave_out_a_oe_n,
   output logic                        wave_out_b,
   output logic                        wave_out_b_oe_n
);
   import tc2_pkg::*;

   typedef struct packed {
      logic [DW-1:0]    ctrl_a;
      logic [DW-1:0]    ctrl_b;
      logic             async_sel;
      logic [DW-1:0]    cnt;
      logic             count_down;
      logic             blk;
      logic [2:0]       flags;
      logic [2:0]       ien;
      logic [DW-1:0]    rdata;
      logic             osc_s1;
      logic             osc_s2;
      logic             osc_d;
      logic [PRE_W-1:0] pre;
      logic [2:0]       irq;
      logic             pin_a;
      logic             pin_oe_n_a;
      logic             pin_b;
      logic             pin_oe_n_b;
   } tc2_state_t;

   tc2_state_t s_r;
   tc2_state_t s_nxt;

   tc2_wgm_t      wgm;
   tc2_kind_t     kind;
   tc2_com_t      com_a;
   tc2_com_t      com_b;
   logic [2:0]    cs;
   logic          base_en;
   logic          tick;
   logic [DW-1:0] top;
   logic          at_top;
   logic          at_bottom;
   logic          at_max;
   logic          update;
   logic          at_clear;
   logic          wr_cnt;
   logic          wr_cmp_a;
   logic          wr_cmp_b;
   logic          force_a;
   logic          force_b;
   logic [DW-1:0] cmp_act_a;
   logic [DW-1:0] cmp_act_b;
   logic [DW-1:0] cmp_view_a;
   logic [DW-1:0] cmp_view_b;
   logic          oc_a;
   logic          oc_b;
   logic          match_a;
   logic          match_b;

   // Mode decode
   assign wgm   = tc2_wgm_t'({s_r.ctrl_b[CB_WGM2],
                              s_r.ctrl_a[CA_WGM_LSB+1:CA_WGM_LSB]});    // see RULE8
   assign com_a = tc2_com_t'(s_r.ctrl_a[CA_COMA_LSB+1:CA_COMA_LSB]);
   assign com_b = tc2_com_t'(s_r.ctrl_a[CA_COMB_LSB+1:CA_COMB_LSB]);
   assign cs    = s_r.ctrl_b[CB_CS_LSB+2:CB_CS_LSB];

   always_comb begin
      unique case (wgm)
         TC2_FAST_MAX, TC2_FAST_A: begin
            kind = TC2_K_FAST;
         end
         TC2_PHASE_MAX, TC2_PHASE_A: begin
            kind = TC2_K_PHASE;
         end
         TC2_NORMAL, TC2_CTC, TC2_RSV4, TC2_RSV6: begin
            kind = TC2_K_NONPWM;
         end
      endcase
   end

   // Bus strobes
   assign wr_cnt   = reg_wr && (reg_addr == ADDR_COUNT);
   assign wr_cmp_a = reg_wr && (reg_addr == ADDR_CMP_A);
   assign wr_cmp_b = reg_wr && (reg_addr == ADDR_CMP_B);
   assign force_a  = reg_wr && (reg_addr == ADDR_CTRL_B) && reg_wdata[CB_FORCE_A];
   assign force_b  = reg_wr && (reg_addr == ADDR_CTRL_B) && reg_wdata[CB_FORCE_B];

   // Timer clock enable: core rate or synchronised oscillator edges, then prescaler
   assign base_en = s_r.async_sel ? (s_r.osc_s2 && !s_r.osc_d) : 1'b1;   // see RULE4 see RULE25

   always_comb begin
      unique case (cs)
         3'h0: tick = 1'b0;                                             // see RULE6
         3'h1: tick = base_en;
         3'h2: tick = base_en && ((s_r.pre & PRE_M8) == PRE_M8);
         3'h3: tick = base_en && ((s_r.pre & PRE_M32) == PRE_M32);
         3'h4: tick = base_en && ((s_r.pre & PRE_M64) == PRE_M64);
         3'h5: tick = base_en && ((s_r.pre & PRE_M128) == PRE_M128);
         3'h6: tick = base_en && ((s_r.pre & PRE_M256) == PRE_M256);
         3'h7: tick = base_en && ((s_r.pre & PRE_M1024) == PRE_M1024);
      endcase
   end

   // Sequence limits
   assign top       = (wgm == TC2_PHASE_A || wgm == TC2_FAST_A) ? cmp_act_a : MAX; // see RULE3
   assign at_top    = (s_r.cnt == top);
   assign at_bottom = (s_r.cnt == BOTTOM);                              // see RULE1
   assign at_max    = (s_r.cnt == MAX);                                 // see RULE2
   assign at_clear  = at_top;
   assign update    = (kind == TC2_K_FAST) ? at_top
                                           : (at_top && !s_r.count_down); // see RULE12

   tc2_chan u_chan_a (
      .core_clk   (core_clk),
      .arst_n     (arst_n),
      .cmp_wr     (wr_cmp_a),
      .wdata      (reg_wdata),
      .force_hit  (force_a),
      .com        (com_a),
      .kind       (kind),
      .tick       (tick),
      .update     (update),
      .blocked    (s_r.blk),
      .count_down (s_r.count_down),
      .at_clear   (at_clear),
      .cnt        (s_r.cnt),
      .cmp_act    (cmp_act_a),
      .cmp_view   (cmp_view_a),
      .oc         (oc_a),
      .match      (match_a)
   );

   tc2_chan u_chan_b (
      .core_clk   (core_clk),
      .arst_n     (arst_n),
      .cmp_wr     (wr_cmp_b),
      .wdata      (reg_wdata),
      .force_hit  (force_b),
      .com        (com_b),
      .kind       (kind),
      .tick       (tick),
      .update     (update),
      .blocked    (s_r.blk),
      .count_down (s_r.count_down),
      .at_clear   (at_clear),
      .cnt        (s_r.cnt),
      .cmp_act    (cmp_act_b),
      .cmp_view   (cmp_view_b),
      .oc         (oc_b),
      .match      (match_b)
   );

   always_comb begin
      logic [2:0] set_f;
      logic [2:0] clr_f;
      set_f = 3'h0;
      clr_f = int_ack;
      s_nxt = s_r;

      // Oscillator pin synchroniser and prescaler
      s_nxt.osc_s1 = osc_in_pin;
      s_nxt.osc_s2 = s_r.osc_s1;
      s_nxt.osc_d  = s_r.osc_s2;
      if (base_en) begin
         s_nxt.pre = s_r.pre + 10'h001;
      end

      // Counting sequence
      if (tick) begin                                                   // see RULE5
         unique case (wgm)
            TC2_NORMAL, TC2_RSV4, TC2_RSV6: begin
               s_nxt.cnt = s_r.cnt + 8'h01;                             // see RULE22
               set_f[FL_OVF] = at_max;
            end
            TC2_CTC: begin
               s_nxt.cnt = match_a ? BOTTOM : s_r.cnt + 8'h01;          // see RULE23
               set_f[FL_OVF] = at_max;
            end
            TC2_FAST_MAX, TC2_FAST_A: begin
               s_nxt.cnt = at_top ? BOTTOM : s_r.cnt + 8'h01;           // see RULE24
               set_f[FL_OVF] = at_top;                                  // see RULE9
            end
            TC2_PHASE_MAX, TC2_PHASE_A: begin
               if (!s_r.count_down) begin
                  s_nxt.count_down = at_top;
                  s_nxt.cnt = at_top ? s_r.cnt - 8'h01 : s_r.cnt + 8'h01;
               end else begin
                  s_nxt.count_down = !at_bottom;
                  s_nxt.cnt = at_bottom ? s_r.cnt + 8'h01 : s_r.cnt - 8'h01;
                  set_f[FL_OVF] = at_bottom;                            // see RULE9
               end
            end
         endcase
         s_nxt.blk = 1'b0;
      end
      if (kind != TC2_K_PHASE) begin
         s_nxt.count_down = 1'b0;
      end
      set_f[FL_CMPA] = match_a;                                         // see RULE10
      set_f[FL_CMPB] = match_b;

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_CTRL_A: s_nxt.ctrl_a = reg_wdata;                      // see RULE16
            ADDR_CTRL_B: s_nxt.ctrl_b = reg_wdata & 8'h3f;
            ADDR_COUNT: begin
               s_nxt.cnt = reg_wdata;                                   // see RULE7
               s_nxt.blk = 1'b1;                                        // see RULE15
            end
            ADDR_FLAGS: clr_f = clr_f | reg_wdata[2:0];                 // see RULE11
            ADDR_IEN:   s_nxt.ien = reg_wdata[2:0];
            ADDR_ASYNC: s_nxt.async_sel = reg_wdata[AS_SEL];
            default: begin
            end
         endcase
      end
      s_nxt.flags = (s_r.flags & ~clr_f) | set_f;
      s_nxt.irq   = s_nxt.flags & s_r.ien;                              // see RULE11

      // Register reads, answered in the next cycle
      s_nxt.rdata = RST_BYTE;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CTRL_A: s_nxt.rdata = s_r.ctrl_a;
            ADDR_CTRL_B: s_nxt.rdata = s_r.ctrl_b;
            ADDR_COUNT:  s_nxt.rdata = s_r.cnt;
            ADDR_CMP_A:  s_nxt.rdata = cmp_view_a;                      // see RULE13
            ADDR_CMP_B:  s_nxt.rdata = cmp_view_b;
            ADDR_FLAGS:  s_nxt.rdata = {5'h00, s_r.flags};
            ADDR_IEN:    s_nxt.rdata = {5'h00, s_r.ien};
            ADDR_ASYNC:  s_nxt.rdata = {7'h00, s_r.async_sel};
            default:     s_nxt.rdata = RST_BYTE;
         endcase
      end

      // Pin override
      s_nxt.pin_a      = (com_a != TC2_COM_OFF) ? oc_a : port_out_a;  // see RULE18
      s_nxt.pin_b      = (com_b != TC2_COM_OFF) ? oc_b : port_out_b;
      s_nxt.pin_oe_n_a = !wave_pin_direction_a;
      s_nxt.pin_oe_n_b = !wave_pin_direction_b;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r            <= '0;
         s_r.pin_oe_n_a <= 1'b1;
         s_r.pin_oe_n_b <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata       = s_r.rdata;
   assign irq             = s_r.irq;
   assign wave_out_a      = s_r.pin_a;
   assign wave_out_a_oe_n = s_r.pin_oe_n_a;
   assign wave_out_b      = s_r.pin_b;
   assign wave_out_b_oe_n = s_r.pin_oe_n_b;

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence cnt_write_s;
      reg_wr && reg_addr == ADDR_COUNT;
   endsequence

   cnt_write_prio_a: assert property (cnt_write_s |=> s_r.cnt == $past(reg_wdata)) // see RULE7
      else $error("counter write lost");

   stopped_hold_a: assert property (cs == CS_STOP && !reg_wr |=> $stable(s_r.cnt)) // see RULE6
      else $error("counter moved while stopped");

   normal_wrap_a: assert property (wgm == TC2_NORMAL && tick && at_max && !reg_wr
                                   |=> s_r.cnt == BOTTOM && s_r.flags[FL_OVF]) // see RULE22
      else $error("normal mode wrap wrong");

   ctc_clear_a: assert property (wgm == TC2_CTC && match_a && !reg_wr
                                 |=> s_r.cnt == BOTTOM) // see RULE23
      else $error("ctc clear missing");

   fast_top_a: assert property (wgm == TC2_FAST_A && tick && s_r.cnt == cmp_act_a && !reg_wr
                                |=> s_r.cnt == BOTTOM) // see RULE24
      else $error("fast pwm top wrong");

   flag_set_a: assert property (match_b |=> s_r.flags[FL_CMPB]) // see RULE10
      else $error("compare flag not set");

   flag_clear_a: assert property (reg_wr && reg_addr == ADDR_FLAGS && reg_wdata[FL_CMPA]
                                  && !match_a |=> !s_r.flags[FL_CMPA]) // see RULE11
      else $error("compare flag not cleared");

   match_block_a: assert property (cnt_write_s ##1 (!reg_wr && tick) |-> !match_a && !match_b) // see RULE15
      else $error("match after counter write");

   phase_turn_a: assert property (wgm == TC2_PHASE_MAX && tick && at_max && !s_r.count_down
                                  && !reg_wr |=> s_r.count_down && s_r.cnt == 8'hfe) // see RULE2
      else $error("phase turn at max wrong");

   buffer_hold_a: assert property (kind != TC2_K_NONPWM && reg_wr && reg_addr == ADDR_CMP_A
                                   && !(tick && update) ##1 !(tick && update)
                                   |-> $stable(cmp_act_a)) // see RULE13
      else $error("buffered compare leaked");

endmodule
`default_nettype wire

// [logic/tc2_pkg.sv]
// Shared constants and types of the eight-bit timer with two compare channels
package tc2_pkg;

   localparam int DW = 8;
   localparam int AW = 4;
   localparam int PRE_W = 10;

   // Register offsets
   localparam logic [AW-1:0] ADDR_CTRL_A = 4'h0;
   localparam logic [AW-1:0] ADDR_CTRL_B = 4'h1;
   localparam logic [AW-1:0] ADDR_COUNT  = 4'h2;
   localparam logic [AW-1:0] ADDR_CMP_A  = 4'h3;
   localparam logic [AW-1:0] ADDR_CMP_B  = 4'h4;
   localparam logic [AW-1:0] ADDR_FLAGS  = 4'h5;
   localparam logic [AW-1:0] ADDR_IEN    = 4'h6;
   localparam logic [AW-1:0] ADDR_ASYNC  = 4'h7;

   // Field positions
   localparam int CA_COMA_LSB = 6;
   localparam int CA_COMB_LSB = 4;
   localparam int CA_WGM_LSB  = 0;
   localparam int CB_FORCE_A  = 7;
   localparam int CB_FORCE_B  = 6;
   localparam int CB_WGM2     = 3;
   localparam int CB_CS_LSB   = 0;
   localparam int FL_OVF      = 0;
   localparam int FL_CMPA     = 1;
   localparam int FL_CMPB     = 2;
   localparam int AS_SEL      = 0;

   // Values
   localparam logic [DW-1:0] BOTTOM   = 8'h00;
   localparam logic [DW-1:0] MAX      = 8'hff;
   localparam logic [DW-1:0] RST_BYTE = 8'h00;
   localparam logic [2:0]    CS_STOP  = 3'h0;

   // Prescaler tap masks: divide by 8, 32, 64, 128, 256, 1024
   localparam logic [PRE_W-1:0] PRE_M8    = 10'h007;
   localparam logic [PRE_W-1:0] PRE_M32   = 10'h01f;
   localparam logic [PRE_W-1:0] PRE_M64   = 10'h03f;
   localparam logic [PRE_W-1:0] PRE_M128  = 10'h07f;
   localparam logic [PRE_W-1:0] PRE_M256  = 10'h0ff;
   localparam logic [PRE_W-1:0] PRE_M1024 = 10'h3ff;

   typedef enum logic [2:0] {
      TC2_NORMAL    = 3'b000,
      TC2_PHASE_MAX = 3'b001,
      TC2_CTC       = 3'b010,
      TC2_FAST_MAX  = 3'b011,
      TC2_RSV4      = 3'b100,
      TC2_PHASE_A   = 3'b101,
      TC2_RSV6      = 3'b110,
      TC2_FAST_A    = 3'b111
   } tc2_wgm_t;

   typedef enum logic [1:0] {
      TC2_COM_OFF    = 2'b00,
      TC2_COM_TOGGLE = 2'b01,
      TC2_COM_CLEAR  = 2'b10,
      TC2_COM_SET    = 2'b11
   } tc2_com_t;

   typedef enum logic [1:0] {
      TC2_K_NONPWM = 2'b00,
      TC2_K_FAST   = 2'b01,
      TC2_K_PHASE  = 2'b10
   } tc2_kind_t;

endpackage

// [logic/tc2_chan.sv]
// One compare channel: compare buffer, active compare value and output state
`timescale 1ns/1ns
`default_nettype none
module tc2_chan (
   // Clock and reset
   input  wire logic                core_clk,
   input  wire logic                arst_n,
   // Processor side
   input  wire logic                cmp_wr,
   input  wire logic [tc2_pkg::DW-1:0] wdata,
   input  wire logic                force_hit,
   input  wire tc2_pkg::tc2_com_t   com,
   // Counter side
   input  wire tc2_pkg::tc2_kind_t  kind,
   input  wire logic                tick,
   input  wire logic                update,
   input  wire logic                blocked,
   input  wire logic                count_down,
   input  wire logic                at_clear,
   input  wire logic [tc2_pkg::DW-1:0] cnt,
   // Results
   output logic [tc2_pkg::DW-1:0]   cmp_act,
   output logic [tc2_pkg::DW-1:0]   cmp_view,
   output logic                     oc,
   output logic                     match
);
   import tc2_pkg::*;

   typedef struct packed {
      logic [DW-1:0] cmp_buf;
      logic [DW-1:0] cmp_act;
      logic          oc;
   } tc2_chan_st_t;

   tc2_chan_st_t s_r;
   tc2_chan_st_t s_nxt;
   logic         buffered;

   assign buffered = (kind != TC2_K_NONPWM);                          // see RULE12
   assign match    = tick && !blocked && (cnt == s_r.cmp_act);        // see RULE10 see RULE15
   assign cmp_act  = s_r.cmp_act;
   assign cmp_view = buffered ? s_r.cmp_buf : s_r.cmp_act;            // see RULE13
   assign oc       = s_r.oc;

   always_comb begin
      s_nxt = s_r;
      if (tick && update && buffered) begin
         s_nxt.cmp_act = s_r.cmp_buf;                                 // see RULE12
      end
      if (cmp_wr) begin
         s_nxt.cmp_buf = wdata;
         if (!buffered) begin
            s_nxt.cmp_act = wdata;                                    // see RULE13
         end
      end
      // Fast PWM restart action at the clear to bottom
      if (kind == TC2_K_FAST && at_clear && tick) begin
         if (com == TC2_COM_CLEAR) begin
            s_nxt.oc = 1'b1;
         end else if (com == TC2_COM_SET) begin
            s_nxt.oc = 1'b0;
         end
      end
      // Compare action; zero mode leaves the state alone
      if (match || (force_hit && kind == TC2_K_NONPWM)) begin        // see RULE14 see RULE19
         unique case (com)                                            // see RULE17
            TC2_COM_OFF: begin
               s_nxt.oc = s_r.oc;
            end
            TC2_COM_TOGGLE: begin
               s_nxt.oc = !s_r.oc;
            end
            TC2_COM_CLEAR: begin
               s_nxt.oc = (kind == TC2_K_PHASE) ? count_down : 1'b0;
            end
            TC2_COM_SET: begin
               s_nxt.oc = (kind == TC2_K_PHASE) ? !count_down : 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// [test/tc2_pin_load.sv]
// Pin load and oscillator model on the waveform and oscillator pins
`timescale 1ns/1ns
`default_nettype none
module tc2_pin_load (
   // Clock
   input  wire logic core_clk,
   // Waveform pins
   input  wire logic wave_out_a,
   input  wire logic wave_out_a_oe_n,
   input  wire logic wave_out_b,
   input  wire logic wave_out_b_oe_n,
   // Oscillator control
   input  wire logic osc_run,
   // Resolved pins
   output logic      pin_a,
   output logic      pin_b,
   output logic      osc_in_pin
);
   logic [1:0] div_r;
   // Undriven pins float to the pull-up level
   assign pin_a = wave_out_a_oe_n ? 1'b1 : wave_out_a;
   assign pin_b = wave_out_b_oe_n ? 1'b1 : wave_out_b;
   initial begin
      div_r = 2'h0;
      osc_in_pin = 1'b0;
   end
   // Oscillator stands low outside runs, eight core cycles a period
   always @(posedge core_clk) begin
      if (osc_run) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) begin
            osc_in_pin <= ~osc_in_pin;
         end
      end else begin
         div_r <= 2'h0;
         osc_in_pin <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// [test/tc2_timer_tb_top.sv]
// Self-checking bench of the eight-bit timer with its pin load model
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tc2_timer_tb_top;
   import tc2_pkg::*;
   logic          core_clk, arst_n, reg_wr, reg_rd, osc_run, osc_in_pin, pin_a, pin_b;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata, d, st;
   logic [2:0]    irq, int_ack;
   logic          port_out_a, port_out_b, dir_a, dir_b;
   logic          wave_out_a, wave_out_a_oe_n, wave_out_b, wave_out_b_oe_n;
   logic [31:0]   rnd;
   logic [1:0]    com_tab [5] = '{2'b11, 2'b10, 2'b01, 2'b01, 2'b00};
   int            miscompares, checks_done, cyc, t;

   tc2_timer tc2_timer_i (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq(irq), .int_ack(int_ack), .osc_in_pin(osc_in_pin), .port_out_a(port_out_a),
      .port_out_b(port_out_b), .wave_pin_direction_a(dir_a), .wave_pin_direction_b(dir_b),
      .wave_out_a(wave_out_a), .wave_out_a_oe_n(wave_out_a_oe_n),
      .wave_out_b(wave_out_b), .wave_out_b_oe_n(wave_out_b_oe_n));
   tc2_pin_load tc2_pin_load_i (.core_clk(core_clk), .wave_out_a(wave_out_a),
      .wave_out_a_oe_n(wave_out_a_oe_n), .wave_out_b(wave_out_b),
      .wave_out_b_oe_n(wave_out_b_oe_n), .osc_run(osc_run), .pin_a(pin_a),
      .pin_b(pin_b), .osc_in_pin(osc_in_pin));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction
   task automatic run(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         miscompares++;
         test_done();
      end
   end

   initial begin
      {arst_n, reg_wr, reg_rd, osc_run, port_out_a, port_out_b, dir_a, dir_b} = '0;
      {reg_addr, reg_wdata, int_ack} = '0;
      rnd = 32'h81d3;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      wr(4'h9, 8'hff);
      for (int a = 0; a < 10; a++) begin
         rd(4'(a), d);
         `CHK(d, RST_BYTE)
      end
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         wr(ADDR_COUNT, rnd[7:0]);
         wr(ADDR_CMP_B, rnd[15:8]);
         run(3);
         rd(ADDR_COUNT, d);
         `CHK(d, rnd[7:0])
         rd(ADDR_CMP_B, d);
         `CHK(d, rnd[15:8])
      end
      $display("Reset and access test done");
      wr(ADDR_IEN, 8'h07);
      wr(ADDR_CTRL_B, 8'h01);
      wr(ADDR_COUNT, 8'hfa);
      run(3);
      rd(ADDR_COUNT, d);
      `CHK(d, 8'hfe)
      rd(ADDR_COUNT, d);
      `CHK(d, BOTTOM)
      rd(ADDR_FLAGS, d);
      `CHK(d[FL_OVF], 1'b1)
      `CHK(irq[0], 1'b1)
      @(posedge core_clk);
      int_ack <= 3'h1;
      @(posedge core_clk);
      int_ack <= 3'h0;
      run(2);
      `CHK(irq[0], 1'b0)
      $display("Normal mode test done");
      wr(ADDR_CTRL_A, 8'h02);
      wr(ADDR_CMP_A, 8'h05);
      wr(ADDR_COUNT, BOTTOM);
      t = 0;
      for (int j = 0; j < 7; j++) begin
         run(j);
         t += j;
         rd(ADDR_COUNT, d);
         `CHK(d, 8'((t + 1) % 6))
         t += 2;
      end
      rd(ADDR_FLAGS, d);
      `CHK(d[FL_CMPA], 1'b1)
      $display("Clear on match test done");
      for (int v = 7; v > 5; v--) begin
         wr(ADDR_CTRL_B, 8'h00);
         wr(ADDR_CTRL_A, 8'h00);
         wr(ADDR_CMP_A, 8'h07);
         wr(ADDR_CMP_B, 8'h07);
         wr(ADDR_COUNT, 8'(v));
         wr(ADDR_FLAGS, 8'h07);
         wr(ADDR_CTRL_B, 8'h01);
         run(3);
         wr(ADDR_CTRL_B, 8'h00);
         rd(ADDR_FLAGS, d);
         `CHK(d[2:1], (v == 6) ? 2'b11 : 2'b00)
      end
      $display("Match blocking test done");
      for (int m = 3; m >= 0; m -= 3) begin
         wr(ADDR_CTRL_A, 8'(m));
         wr(ADDR_CMP_A, 8'h20);
         wr(ADDR_COUNT, 8'h10);
         wr(ADDR_FLAGS, 8'h07);
         wr(ADDR_CTRL_B, 8'h01);
         run(30);
         wr(ADDR_CTRL_B, 8'h00);
         rd(ADDR_FLAGS, d);
         `CHK(d[FL_CMPA], m == 0)
         rd(ADDR_CMP_A, d);
         `CHK(d, 8'h20)
      end
      $display("Compare buffering test done");
      wr(ADDR_FLAGS, 8'h07);
      rnd = xs(rnd);
      port_out_a <= rnd[0];
      st = 8'h00;
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL_A, {com_tab[i], 6'h00});
         wr(ADDR_CTRL_B, 8'h80);
         run(2);
         st[0] = (com_tab[i] == 2'b01) ? ~st[0] : (com_tab[i] == 2'b00) ? st[0] : com_tab[i][0];
         `CHK(wave_out_a, (com_tab[i] != 2'b00) ? st[0] : port_out_a)
         wr(ADDR_CTRL_A, 8'h40);
         run(2);
         `CHK(wave_out_a, st[0])
      end
      rd(ADDR_FLAGS, d);
      `CHK(d[FL_CMPA], 1'b0)
      @(posedge core_clk);
      dir_a <= 1'b1;
      run(2);
      `CHK(pin_a, st[0])
      wr(ADDR_CTRL_A, 8'h43);
      run(2);
      `CHK(wave_out_a, st[0])
      $display("Output unit test done");
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_COUNT, 8'h30);
      wr(ADDR_ASYNC, 8'h01);
      wr(ADDR_CTRL_B, 8'h01);
      run(20);
      rd(ADDR_COUNT, d);
      `CHK(d, 8'h30)
      @(posedge core_clk);
      osc_run <= 1'b1;
      run(40);
      osc_run <= 1'b0;
      run(10);
      rd(ADDR_COUNT, d);
      `CHK(d, 8'h35)
      $display("Oscillator clock test done");
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_CTRL_B, 8'h00);
         wr(ADDR_ASYNC, 8'h00);
         wr(ADDR_CTRL_A, k ? 8'h21 : 8'h23);
         wr(ADDR_CMP_B, 8'h10);
         wr(ADDR_COUNT, k ? 8'hf0 : 8'h00);
         wr(ADDR_FLAGS, 8'h07);
         wr(ADDR_CTRL_B, k ? 8'h01 : 8'h09);
         run(40);
         wr(ADDR_CTRL_B, k ? 8'h00 : 8'h08);
         rd(ADDR_COUNT, d);
         `CHK(d, k ? 8'he4 : 8'h09)
         rd(ADDR_FLAGS, d);
         `CHK(d[2:0], k ? 3'b000 : 3'b111)
         `CHK({wave_out_b, wave_out_b_oe_n}, 2'b11)
         `CHK(pin_b, 1'b1)
      end
      $display("Waveform mode test done");
      test_done();
   end
endmodule
`default_nettype wire
